// ===== hw/sideband_pkg.sv
// Shared constants and carrier types for the sideband status pin block.
// Assumes a single 125 MHz core clock and an active-low asynchronous reset.
package sideband_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int POLL_PERIOD_NS = 20_000_000;
    localparam int POLL_CYCLES = POLL_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [21:0] POLL_FIRST = 22'h000002;
    localparam int EE_QTR_NS = 2500;
    localparam int EE_QTR_CYCLES = EE_QTR_NS / CLK_PERIOD_NS;

    // ==========================================================
    // Configuration memory layout
    localparam logic [7:0] EE_DEV_WR = 8'hA0;
    localparam logic [7:0] EE_DEV_RD = 8'hA1;
    localparam logic [7:0] EE_CFG_ADDR = 8'h08;
    localparam logic [2:0] EE_LAST_BYTE = 3'h5;
    localparam logic [2:0] EE_FIRST_RD = 3'h3;
    localparam int CFG_MEDIA_EN_BIT = 0;
    localparam int CFG_MEDIA_POL_BIT = 1;
    localparam int CFG_SPEED_IND_BIT = 2;
    localparam int CFG_DEV_DETECT_BIT = 6;
    localparam int SPEED_PIN = 2;

    // ==========================================================
    // Sense codes
    localparam logic [7:0] ASC_NO_MEDIUM = 8'h3A;
    localparam logic [7:0] ASC_CHANGED = 8'h28;
    localparam logic [7:0] ASQ_NONE = 8'h00;

    typedef enum logic [1:0] {
        EE_START = 2'b00,
        EE_BYTE = 2'b01,
        EE_STOP = 2'b10,
        EE_DONE = 2'b11
    } ee_state_t;

    typedef struct packed {
        logic dev_detect_en;
        logic speed_ind_en;
        logic media_pol;
        logic media_en;
    } cfg_flags_t;

    typedef struct packed {
        logic [5:0] rsvd_hi;
        logic high_speed;
        logic bus_powered;
        logic [1:0] rsvd_lo;
        logic [5:0] gpio;
    } int_report_t;

endpackage

// ===== hw/level_sync.sv
// Two-flop synchroniser for a group of independent levels.
// Assumes each bit is a slow level; no bus coherence is implied.
`timescale 1ns/100ps
module level_sync #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

// ===== hw/sideband_status.sv
// Sideband status and control pins of the storage bridge.
// Assumes the USB core supplies speed, suspend and interrupt pipe strobes on core_clk.
`timescale 1ns/100ps
module sideband_status
    import sideband_pkg::*;
#(
    parameter int POLL_CYC = POLL_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic bus_power_present,
    input wire logic service_request_pin,
    input wire logic media_detect_input,
    input wire logic bus_powered_select,
    input wire logic [5:0] gpio_in,
    input wire logic high_speed_flag,
    input wire logic suspend,
    input wire logic int_in_token,
    input wire logic int_ack,
    input wire logic sense_ack,
    input wire logic vendor_gpio_we,
    input wire logic [5:0] vendor_gpio_level,
    input wire logic [5:0] vendor_gpio_dir,
    input wire logic eeprom_sda_in,
    output logic eeprom_sda_out,
    output logic eeprom_sda_oe,
    output logic eeprom_scl_out,
    output logic eeprom_scl_oe,
    output logic dplus_pullup_en,
    output logic [5:0] gpio_out,
    output logic [5:0] gpio_oe,
    output logic int_nak,
    output logic int_data_valid,
    output logic [15:0] int_data,
    output logic sense_valid,
    output logic [7:0] additional_sense_code,
    output logic [7:0] sense_qualifier,
    output logic low_power_indicator_out,
    output logic low_power_indicator_oe,
    output logic config_done,
    output logic device_detect_req
);
    // ==========================================================
    // Input synchronisers
    logic [10:0] sync_q;
    logic vbus_s, srq_s, media_s, buspwr_s, sda_s;
    logic [5:0] gpio_s;

    level_sync #(.W(11)) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .d({gpio_in, eeprom_sda_in, bus_powered_select, media_detect_input,
            service_request_pin, bus_power_present}),
        .q(sync_q)
    );
    assign vbus_s = sync_q[0];
    assign srq_s = sync_q[1];
    assign media_s = sync_q[2];
    assign buspwr_s = sync_q[3];
    assign sda_s = sync_q[4];
    assign gpio_s = sync_q[10:5];

    // ==========================================================
    // Configuration read over the two-wire port
    ee_state_t ee_state_reg;
    logic [8:0] qdiv_reg;
    logic [1:0] q_reg;
    logic [3:0] bit_reg;
    logic [2:0] byte_reg;
    logic [7:0] rx_reg;
    logic [7:0] cfg_mem [3];
    logic scl_oe_reg, sda_oe_reg, cfg_done_reg;
    cfg_flags_t cfg;

    wire qtick = (qdiv_reg == 9'(EE_QTR_CYCLES - 1));
    wire slot_end = qtick && (q_reg == 2'h3);
    wire ee_wr = (byte_reg < EE_FIRST_RD);
    wire [7:0] tx_byte = (byte_reg == 3'h0) ? EE_DEV_WR :
                         (byte_reg == 3'h1) ? EE_CFG_ADDR : EE_DEV_RD;
    wire tx_bit = tx_byte[3'(4'h7 - bit_reg)];
    wire scl_lo = (ee_state_reg == EE_START || ee_state_reg == EE_BYTE) ?
                  (q_reg == 2'h0 || q_reg == 2'h3) :
                  (ee_state_reg == EE_STOP && q_reg == 2'h0);
    wire byte_sda_lo = (bit_reg < 4'h8) ? (ee_wr && !tx_bit) :
                       (!ee_wr && byte_reg != EE_LAST_BYTE);
    wire sda_lo = (ee_state_reg == EE_START) ? (q_reg >= 2'h2) :
                  (ee_state_reg == EE_STOP) ? (q_reg < 2'h2) :
                  (ee_state_reg == EE_BYTE) && byte_sda_lo;
    wire rd_sample = qtick && q_reg == 2'h2 && ee_state_reg == EE_BYTE && !ee_wr
                     && bit_reg < 4'h8;

    assign cfg.media_en = cfg_mem[0][CFG_MEDIA_EN_BIT];
    assign cfg.media_pol = cfg_mem[0][CFG_MEDIA_POL_BIT];
    assign cfg.speed_ind_en = cfg_mem[0][CFG_SPEED_IND_BIT];
    assign cfg.dev_detect_en = cfg_mem[0][CFG_DEV_DETECT_BIT];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            qdiv_reg <= '0;
            q_reg <= '0;
        end else begin
            qdiv_reg <= (qtick || ee_state_reg == EE_DONE) ? 9'h000 : qdiv_reg + 9'h001;
            q_reg <= qtick ? q_reg + 2'h1 : q_reg;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ee_state_reg <= EE_START;
            bit_reg <= '0;
            byte_reg <= '0;
            rx_reg <= '0;
            cfg_mem <= '{default: 8'h00};
            cfg_done_reg <= 1'b0;
        end else begin
            if (rd_sample) begin
                rx_reg <= {rx_reg[6:0], sda_s};
            end
            if (slot_end) begin
                case (ee_state_reg)
                    EE_START: begin
                        ee_state_reg <= EE_BYTE;
                        bit_reg <= 4'h0;
                    end
                    EE_BYTE: begin
                        if (bit_reg == 4'h8) begin
                            bit_reg <= 4'h0;
                            if (!ee_wr) begin
                                cfg_mem[2'(byte_reg - EE_FIRST_RD)] <= rx_reg;
                            end
                            if (byte_reg == EE_LAST_BYTE) begin
                                ee_state_reg <= EE_STOP;
                            end else begin
                                byte_reg <= byte_reg + 3'h1;
                                if (byte_reg == 3'h1) begin
                                    ee_state_reg <= EE_START;
                                end
                            end
                        end else begin
                            bit_reg <= bit_reg + 4'h1;
                        end
                    end
                    EE_STOP: begin
                        ee_state_reg <= EE_DONE;
                        cfg_done_reg <= 1'b1;
                    end
                    default: ee_state_reg <= EE_DONE;
                endcase
            end
        end
    end

    // ==========================================================
    // Bus power polling and D+ pull-up
    logic [21:0] poll_reg, gap_reg;
    logic pullup_reg, seen_tick_reg;
    wire poll_tick = (poll_reg == 22'h000000);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            poll_reg <= POLL_FIRST;
            pullup_reg <= 1'b0;
        end else begin
            poll_reg <= poll_tick ? 22'(POLL_CYC - 1) : poll_reg - 22'h000001;
            if (poll_tick) begin
                pullup_reg <= vbus_s;
            end
        end
    end

    // ==========================================================
    // Interrupt pipe status report
    logic srq_prev_reg, pending_reg, nak_reg, dvalid_reg;
    int_report_t snap_reg, data_reg;
    int_report_t snap_now;
    wire srq_rise = srq_s && !srq_prev_reg;

    always_comb begin
        snap_now = '0;
        snap_now.high_speed = high_speed_flag;
        snap_now.bus_powered = buspwr_s;
        snap_now.gpio = gpio_s;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            srq_prev_reg <= 1'b0;
            pending_reg <= 1'b0;
            snap_reg <= '0;
            nak_reg <= 1'b0;
            dvalid_reg <= 1'b0;
            data_reg <= '0;
        end else begin
            srq_prev_reg <= srq_s;
            if (srq_rise) begin
                snap_reg <= snap_now;
            end
            pending_reg <= srq_rise || (pending_reg && !int_ack);
            nak_reg <= int_in_token && !pending_reg;
            dvalid_reg <= int_in_token && pending_reg;
            data_reg <= (int_in_token && pending_reg) ? snap_reg : '0;
        end
    end

    // ==========================================================
    // Removable media sense
    logic media_prev_reg, changed_reg, sense_v_reg;
    logic [7:0] asc_reg;
    wire media_present = !cfg.media_en || (media_s == cfg.media_pol);
    wire media_back = media_present && !media_prev_reg;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            media_prev_reg <= 1'b1;
            changed_reg <= 1'b0;
            sense_v_reg <= 1'b0;
            asc_reg <= ASQ_NONE;
        end else begin
            media_prev_reg <= media_present;
            changed_reg <= media_back || (changed_reg && !sense_ack);
            sense_v_reg <= !media_present || changed_reg;
            asc_reg <= !media_present ? ASC_NO_MEDIUM :
                       changed_reg ? ASC_CHANGED : ASQ_NONE;
        end
    end

    // ==========================================================
    // General purpose pins, low-power indicator, start-up detection
    logic [5:0] level_reg, dir_reg, gout_reg, goe_reg;
    logic lp_oe_reg, detect_reg, done_prev_reg;
    logic [5:0] gout_next, goe_next;

    always_comb begin
        gout_next = level_reg;
        goe_next = dir_reg;
        if (cfg_done_reg && cfg.speed_ind_en) begin
            gout_next[SPEED_PIN] = !high_speed_flag;
            goe_next[SPEED_PIN] = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            level_reg <= '0;
            dir_reg <= '0;
            gout_reg <= '0;
            goe_reg <= '0;
            lp_oe_reg <= 1'b0;
            detect_reg <= 1'b0;
            done_prev_reg <= 1'b0;
        end else begin
            done_prev_reg <= cfg_done_reg;
            if (vendor_gpio_we) begin
                level_reg <= vendor_gpio_level;
                dir_reg <= vendor_gpio_dir;
            end else if (cfg_done_reg && !done_prev_reg) begin
                level_reg <= cfg_mem[1][5:0];
                dir_reg <= cfg_mem[2][5:0];
            end
            gout_reg <= gout_next;
            goe_reg <= goe_next;
            lp_oe_reg <= !suspend;
            detect_reg <= cfg_done_reg && !done_prev_reg && cfg.dev_detect_en;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            gap_reg <= '0;
            seen_tick_reg <= 1'b0;
        end else begin
            scl_oe_reg <= scl_lo;
            sda_oe_reg <= sda_lo;
            gap_reg <= poll_tick ? 22'h000000 : gap_reg + 22'h000001;
            seen_tick_reg <= seen_tick_reg || poll_tick;
        end
    end

    assign eeprom_scl_out = 1'b0;
    assign eeprom_sda_out = 1'b0;
    assign eeprom_scl_oe = scl_oe_reg;
    assign eeprom_sda_oe = sda_oe_reg;
    assign config_done = cfg_done_reg;
    assign dplus_pullup_en = pullup_reg;
    assign gpio_out = gout_reg;
    assign gpio_oe = goe_reg;
    assign int_nak = nak_reg;
    assign int_data_valid = dvalid_reg;
    assign int_data = data_reg;
    assign sense_valid = sense_v_reg;
    assign additional_sense_code = asc_reg;
    assign sense_qualifier = ASQ_NONE;
    assign low_power_indicator_out = 1'b0;
    assign low_power_indicator_oe = lp_oe_reg;
    assign device_detect_req = detect_reg;

    // ==========================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_request;
        srq_rise;
    endsequence
    sequence s_armed;
        pending_reg ##0 (snap_reg == $past(snap_now));
    endsequence

    a_pullup_follow: assert property (poll_tick |=> pullup_reg == $past(vbus_s))
        else $error("pull-up did not follow bus power sample");
    a_poll_period: assert property (poll_tick && seen_tick_reg |->
        gap_reg == 22'(POLL_CYC - 1)) else $error("bus power poll spacing wrong");
    a_speed_pin: assert property (cfg_done_reg && cfg.speed_ind_en |=>
        gout_reg[SPEED_PIN] == !$past(high_speed_flag) && goe_reg[SPEED_PIN])
        else $error("speed indicator pin wrong");
    a_nak_idle: assert property (int_in_token && !pending_reg |=> nak_reg && !dvalid_reg)
        else $error("idle interrupt request not refused");
    a_report_map: assert property (dvalid_reg |-> data_reg == $past(snap_reg) &&
        data_reg.rsvd_hi == 6'h00 && data_reg.rsvd_lo == 2'h0)
        else $error("report differs from latched snapshot");
    a_arm_pending: assert property (s_request |=> s_armed)
        else $error("request pin did not arm the report");
    a_clear_pending: assert property (int_ack && !srq_rise |=> !pending_reg)
        else $error("pending not cleared after host read");
    a_media_absent: assert property (!media_present |-> ##[1:2]
        sense_v_reg && asc_reg == ASC_NO_MEDIUM) else $error("no medium sense missing");
    a_media_back: assert property (media_back ##1 !sense_ack && media_present |=>
        asc_reg == ASC_CHANGED) else $error("medium changed sense missing");
    a_skip_detect: assert property (detect_reg |-> cfg.dev_detect_en)
        else $error("detection started while disabled");
    a_low_power_indicator_pin: assert property (suspend |=> !lp_oe_reg)
        else $error("low power indicator driven in suspend");
    a_eeprom_quiet: assert property (cfg_done_reg |=> !scl_oe_reg && !sda_oe_reg)
        else $error("two-wire port active after start-up");
endmodule

// ===== dv/cfg_eeprom_model.sv
// Behavioural two-wire configuration memory that answers the bridge at start-up.
// Assumes an open-drain wire with a pull-up, resolved by the bench from both enables.
`timescale 1ns/100ps
module cfg_eeprom_model (
    input wire logic scl,
    input wire logic sda,
    input wire logic [7:0] byte8,
    input wire logic [7:0] byte9,
    input wire logic [7:0] byte10,
    output logic sda_oe
);
    int cnt = -1;
    logic first = 1'b0;
    logic rd = 1'b0;
    logic [7:0] sh = 8'h00;
    logic [7:0] ptr = 8'h00;
    logic [7:0] cur = 8'hFF;

    initial sda_oe = 1'b0;

    // ==========================================================
    // Framing
    // A start condition, repeated or not, restarts byte framing.
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            cnt = -1;
            first = 1'b1;
            rd = 1'b0;
            sda_oe = 1'b0;
        end
    end

    // A master nack in the acknowledge slot ends the read burst.
    always @(posedge scl) begin
        if (cnt >= 0 && cnt < 8) sh = {sh[6:0], sda};
        else if (cnt == 8 && rd && first == 1'b0) rd = !sda;
    end

    // ==========================================================
    // Driving
    always @(negedge scl) begin
        cnt = (cnt == 8) ? 0 : cnt + 1;
        sda_oe = 1'b0;
        if (cnt == 8) begin
            if (first) rd = (sh == 8'hA1);
            else if (!rd) ptr = sh;
            sda_oe = first || !rd;
            first = 1'b0;
        end else if (rd) begin
            if (cnt == 0) begin
                cur = (ptr == 8'h08) ? byte8 : (ptr == 8'h09) ? byte9 :
                      (ptr == 8'h0A) ? byte10 : 8'hFF;
                ptr = ptr + 8'h01;
            end
            sda_oe = !cur[7 - cnt];
        end
    end
endmodule

// ===== dv/sideband_status_bench.sv
// Self-checking bench for the sideband status pin block.
// Assumes the configuration memory model answers byte 8 = 0x47, 0x09 = 0x2D, 0x0A = 0x13.
`timescale 1ns/100ps
module sideband_status_bench;
    import sideband_pkg::*;
    localparam int POLL = 50;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic bus_power_present = 1'b1;
    logic service_request_pin = 1'b0;
    logic media_detect_input = 1'b1;
    logic bus_powered_select = 1'b0;
    logic [5:0] gpio_in = 6'h00;
    logic high_speed_flag = 1'b1;
    logic suspend = 1'b0;
    logic int_in_token = 1'b0;
    logic int_ack = 1'b0;
    logic sense_ack = 1'b0;
    logic vendor_gpio_we = 1'b0;
    logic [5:0] vendor_gpio_level = 6'h00;
    logic [5:0] vendor_gpio_dir = 6'h00;
    logic eeprom_sda_oe, eeprom_scl_oe, mem_oe, dplus_pullup_en, int_nak, int_data_valid;
    logic eeprom_sda_out, eeprom_scl_out;
    logic sense_valid, low_power_indicator_out, low_power_indicator_oe;
    logic config_done, device_detect_req;
    logic [5:0] gpio_out, gpio_oe;
    logic [15:0] int_data;
    logic [7:0] additional_sense_code, sense_qualifier;
    logic [16:0] notes[$];
    logic [16:0] note;
    int n_mismatch = 0;
    int n_tests = 0;
    int n_detect = 0;
    int cycles = 0;
    wire eeprom_sda_in = (eeprom_sda_oe ? eeprom_sda_out : 1'b1) && !mem_oe;
    wire scl_line = eeprom_scl_oe ? eeprom_scl_out : 1'b1;

    always #4 core_clk = ~core_clk;

    sideband_status #(.POLL_CYC(POLL)) dut_u (.core_clk, .rst_n, .bus_power_present,
        .service_request_pin, .media_detect_input, .bus_powered_select, .gpio_in,
        .high_speed_flag, .suspend, .int_in_token, .int_ack, .sense_ack, .vendor_gpio_we,
        .vendor_gpio_level, .vendor_gpio_dir, .eeprom_sda_in, .eeprom_sda_out,
        .eeprom_sda_oe, .eeprom_scl_out, .eeprom_scl_oe, .dplus_pullup_en, .gpio_out,
        .gpio_oe, .int_nak, .int_data_valid, .int_data, .sense_valid, .additional_sense_code,
        .sense_qualifier, .low_power_indicator_out, .low_power_indicator_oe, .config_done,
        .device_detect_req);

    // The board holds one removable master and a fixed slave at address 1, so detection is on.
    cfg_eeprom_model mem_u (.scl(scl_line), .sda(eeprom_sda_in), .byte8(8'h47),
        .byte9(8'h2D), .byte10(8'h13), .sda_oe(mem_oe));

    // ==========================================================
    // Tasks
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // One interrupt pipe request; the host acknowledges data in the cycle it appears.
    task automatic tok(input logic nak, input logic [15:0] d);
        notes.push_back({nak, d});
        int_in_token <= 1'b1;
        tick(1);
        int_in_token <= 1'b0;
        int_ack <= !nak;
        tick(1);
        int_ack <= 1'b0;
    endtask

    function automatic logic [15:0] rep(input logic hs, input logic bp, input logic [5:0] g);
        int_report_t r;
        r = '0;
        r.high_speed = hs;
        r.bus_powered = bp;
        r.gpio = g;
        return r;
    endfunction

    // Speed indicator is enabled by the configuration, so pin 2 drives the speed once configuration is done.
    function automatic logic [23:0] gexp(input logic [5:0] lv, input logic [5:0] dr,
                                          input logic hs);
        logic [5:0] o;
        o = lv;
        o[SPEED_PIN] = !hs;
        return {6'h00, o, 6'h00, dr | 6'h04};
    endfunction

    // ==========================================================
    // Watchers
    always @(posedge core_clk) begin
        cycles++;
        if (device_detect_req === 1'b1) n_detect++;
        if (cycles == 95000) begin
            n_mismatch++;
            stop_test();
        end
    end

    always @(posedge core_clk) begin
        if (int_data_valid === 1'b1 || int_nak === 1'b1) begin
            if (notes.size() == 0) begin
                chk("unexpected pipe answer", 24'h000000, 24'h000001);
            end else begin
                note = notes.pop_front();
                chk("pipe answer", {7'h00, note}, {7'h00, int_nak, int_data});
            end
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [5:0] g;
        logic hs;
        logic bp;
        void'($urandom(32'h90BF));
        tick(20);
        rst_n <= 1'b1;
        tick(4);
        chk("pull-up at start", 24'h000001, {23'h0, dplus_pullup_en});
        for (int i = 0; i < 90000 && config_done !== 1'b1; i++) tick(1);
        tick(2);
        chk("config done", 24'h000001, {23'h0, config_done});
        chk("detect pulses", 24'h000001, 24'(n_detect));
        chk("gpio defaults", gexp(6'h2D, 6'h13, 1'b1), {6'h00, gpio_out, 6'h00, gpio_oe});
        high_speed_flag <= 1'b0;
        tick(3);
        chk("speed pin", gexp(6'h2D, 6'h13, 1'b0), {6'h00, gpio_out, 6'h00, gpio_oe});
        high_speed_flag <= 1'b1;
        bus_power_present <= 1'b0;
        tick(POLL + 5);
        chk("pull-up off", 24'h000000, {23'h0, dplus_pullup_en});
        bus_power_present <= 1'b1;
        tick(POLL + 5);
        chk("pull-up on", 24'h000001, {23'h0, dplus_pullup_en});
        tok(1'b1, 16'h0000);
        tok(1'b1, 16'h0000);
        repeat (4) begin
            g = 6'($urandom);
            hs = 1'($urandom);
            bp = 1'($urandom);
            gpio_in <= g;
            high_speed_flag <= hs;
            bus_powered_select <= bp;
            tick(4);
            service_request_pin <= 1'b1;
            tick(6);
            gpio_in <= ~g;
            tick(4);
            tok(1'b0, rep(hs, bp, g));
            tok(1'b1, 16'h0000);
            service_request_pin <= 1'b0;
            tick(4);
        end
        high_speed_flag <= 1'b1;
        tick(2);
        chk("sense idle", 24'h000000, {7'h00, sense_valid, additional_sense_code,
            sense_qualifier});
        media_detect_input <= 1'b0;
        tick(5);
        chk("sense absent", {8'h01, ASC_NO_MEDIUM, ASQ_NONE}, {7'h00, sense_valid,
            additional_sense_code, sense_qualifier});
        media_detect_input <= 1'b1;
        tick(5);
        chk("sense changed", {8'h01, ASC_CHANGED, ASQ_NONE}, {7'h00, sense_valid,
            additional_sense_code, sense_qualifier});
        sense_ack <= 1'b1;
        tick(1);
        sense_ack <= 1'b0;
        tick(3);
        chk("sense cleared", 24'h000000, {7'h00, sense_valid, additional_sense_code,
            sense_qualifier});
        repeat (3) begin
            g = 6'($urandom);
            vendor_gpio_level <= g;
            vendor_gpio_dir <= ~g;
            vendor_gpio_we <= 1'b1;
            tick(1);
            vendor_gpio_we <= 1'b0;
            tick(3);
            chk("vendor gpio", gexp(g, ~g, 1'b1), {6'h00, gpio_out, 6'h00, gpio_oe});
        end
        suspend <= 1'b1;
        tick(3);
        chk("low power suspended", 24'h000000,
            {22'h0, low_power_indicator_out, low_power_indicator_oe});
        suspend <= 1'b0;
        tick(3);
        chk("low power active", 24'h000001,
            {22'h0, low_power_indicator_out, low_power_indicator_oe});
        chk("notes left", 24'h000000, 24'(notes.size()));
        stop_test();
    end
endmodule
